// >>> rtl/timer2_capture_reload_baud.sv
// timer2_capture_reload_baud: 16-bit timer/counter with capture, reload and baud modes
// assumes pins already synchronous to REF_CLK_IN and an AXI4-Lite master
// Overview of operation
// - one 16-bit counter serves as interval timer or event counter
// - capture, auto-reload and baud modes selected by control bits
// - select 0 counts clock divided by twelve (two in baud mode), 1 counts count-pin falls
// - counter runs only while run control is set
// - overflow flag set on overflow, held until software clears it
// - overflow flag never set while either serial clock select is set
// - external flag set by trigger fall when enabled; software clears it
// - enabled interrupt requested while external flag is set
// - no external flag interrupt while down count enabled
// - receive clock select routes our overflow pulses to serial receive
// - transmit clock select routes our overflow pulses to serial transmit
// - trigger fall capture or reload allowed only when not clocking serial
// - trigger enable cleared ignores trigger pin for capture and reload
// - capture select with enable captures on each trigger fall
// - reload select reloads on overflow and on enabled trigger falls
// - serial clock select forces reload on overflow, ignoring capture select
// - count from count pin; trigger pin gives reload, capture, direction
// - reload loads counter bytes from the reload/capture pair
// - down count: low trigger counts down, underflow at reload loads ffff
// - baud mode counts at half rate; baud is overflow rate over sixteen
// - interrupt asserted when enabled while overflow flag is set, or external flag with down count disabled
`timescale 1ns/1ns
module timer2_capture_reload_baud (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic SRST_IN,
   // axi4-lite write
   input wire logic [7:0] AWADDR_IN,
   input wire logic AWVALID_IN,
   output logic AWREADY_OUT,
   input wire logic [31:0] WDATA_IN,
   input wire logic [3:0] WSTRB_IN,
   input wire logic WVALID_IN,
   output logic WREADY_OUT,
   output logic [1:0] BRESP_OUT,
   output logic BVALID_OUT,
   input wire logic BREADY_IN,
   // axi4-lite read
   input wire logic [7:0] ARADDR_IN,
   input wire logic ARVALID_IN,
   output logic ARREADY_OUT,
   output logic [31:0] RDATA_OUT,
   output logic [1:0] RRESP_OUT,
   output logic RVALID_OUT,
   input wire logic RREADY_IN,
   // pins and system
   input wire logic COUNT_PIN_IN,
   input wire logic TRIGGER_PIN_IN,
   input wire logic IRQ_ENABLE_IN,
   output logic IRQ_OUT,
   output logic RX_BAUD_TICK_OUT,
   output logic TX_BAUD_TICK_OUT,
   output logic [1:0] MODE_OUT
);
   import timer2_pkg::*;

   logic [7:0] counter_control_reg;
   logic down_count_enable_reg;
   logic [15:0] reload_capture_reg;
   logic [15:0] count_reg;
   logic count_pin_reg;
   logic trigger_pin_reg;
   logic [3:0] presc_reg;
   logic aw_held_reg;
   logic w_held_reg;
   wr_req_t wr_reg;
   op_mode_t mode_next;

   wire overflow_flag = counter_control_reg[`BIT_OVF];
   wire external_event_flag = counter_control_reg[`BIT_EXF];
   wire rx_clock_select = counter_control_reg[`BIT_RCLK];
   wire tx_clock_select = counter_control_reg[`BIT_TX_CLOCK_SELECT];
   wire external_trigger_enable = counter_control_reg[`BIT_EXEN];
   wire run_control = counter_control_reg[`BIT_RUN];
   wire counter_select = counter_control_reg[`BIT_CSEL];
   wire capture_reload_select = counter_control_reg[`BIT_CPRL];
   // either serial select turns the block into a baud generator
   wire baud_mode = rx_clock_select | tx_clock_select;

   // edge detect on registered samples; pins are already synchronous
   wire count_fall = count_pin_reg & ~COUNT_PIN_IN;
   wire trigger_fall = trigger_pin_reg & ~TRIGGER_PIN_IN;

   // prescaler: twelve in timer mode, two in baud mode
   wire [3:0] presc_div = baud_mode ? `STATE_DIV : `MACHINE_DIV;
   wire presc_tick = (presc_reg >= presc_div - 4'd1);
   wire tick = run_control & (counter_select ? count_fall : presc_tick);

   // direction only meaningful in reload mode with down count enabled
   wire down_mode = down_count_enable_reg & ~baud_mode & ~capture_reload_select;
   // the direction follows the pin live and takes effect at the next tick
   wire count_down = down_mode & ~TRIGGER_PIN_IN;
   wire up_wrap = tick & ~count_down & (count_reg == `COUNT_TOP);
   // underflow is taken on the down tick that leaves the reload value
   wire down_wrap = tick & count_down & (count_reg == reload_capture_reg);
   // the count tops out at all ones; wrap and reload share one edge
   wire wrap = up_wrap | down_wrap;

   // trigger capture and reload: blocked in baud mode, ignored without enable
   // a down count takes the trigger pin as direction, so its falls do nothing there
   wire trig_event = trigger_fall & external_trigger_enable;
   wire trig_act = trig_event & ~baud_mode & ~down_mode;
   wire do_capture = trig_act & capture_reload_select;
   wire do_reload = (up_wrap & (baud_mode | ~capture_reload_select))
      | (trig_act & ~capture_reload_select);
   // baud mode still flags trigger falls as an extra interrupt source
   wire exf_set = (trig_event & ~down_mode) | (down_mode & wrap);
   wire ovf_set = wrap & ~baud_mode;

   // bus strobes: a write lands once, at the edge after both halves are held,
   // so a flag that hardware set in the meantime is not cleared a second time
   // the bus is one write and one read deep; a new address waits for the answer
   wire wr_fire = aw_held_reg & w_held_reg & ~BVALID_OUT;
   wire [7:0] wr_addr = wr_reg.addr;
   wire [31:0] wr_data = wr_reg.data;
   wire [3:0] wr_strb = wr_reg.strb;
   // an unmapped or read-only address gets an error answer and changes nothing
   wire wr_ctrl = wr_fire & (wr_addr == `CTRL_OFFSET) & wr_strb[0];
   wire wr_mode = wr_fire & (wr_addr == `MODE_OFFSET) & wr_strb[0];
   wire wr_rcap = wr_fire & (wr_addr == `RCAP_OFFSET);
   wire wr_cnt = wr_fire & (wr_addr == `COUNT_OFFSET);
   wire wr_known = (wr_addr == `CTRL_OFFSET) | (wr_addr == `MODE_OFFSET)
      | (wr_addr == `RCAP_OFFSET) | (wr_addr == `COUNT_OFFSET);

   // samples start at the idle high level, so reset release makes no false fall
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         count_pin_reg <= 1'b1;
         trigger_pin_reg <= 1'b1;
      end else begin
         count_pin_reg <= COUNT_PIN_IN;
         trigger_pin_reg <= TRIGGER_PIN_IN;
      end
   end

   // the prescaler restarts whenever counting stops or comes from the pin,
   // so the first internal tick after run is a full period away
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN || !run_control || counter_select || presc_tick) begin
         presc_reg <= 4'h0;
      end else begin
         presc_reg <= presc_reg + 4'd1;
      end
   end

   // control register: hardware set wins over a software clear
   // writing the control word writes the flags too: a zero clears them
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         counter_control_reg <= `CTRL_RESET;
      end else begin
         if (wr_ctrl) begin
            counter_control_reg <= wr_data[7:0];
         end
         if (ovf_set) begin
            counter_control_reg[`BIT_OVF] <= 1'b1;
         end
         if (exf_set) begin
            // toggles as a 17th bit in down count mode
            counter_control_reg[`BIT_EXF] <= down_mode ? ~external_event_flag : 1'b1;
         end
      end
   end

   // only bit 0 of the mode word is kept; the other bits read back as zero
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         down_count_enable_reg <= 1'b0;
      end else if (wr_mode) begin
         down_count_enable_reg <= wr_data[0];
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         reload_capture_reg <= `RCAP_RESET;
      // a capture wins over a software write in the same cycle
      end else if (do_capture) begin
         reload_capture_reg <= count_reg;
      // both bytes of the reload pair and the count follow the write strobes
      end else if (wr_rcap) begin
         if (wr_strb[0]) reload_capture_reg[7:0] <= wr_data[7:0];
         if (wr_strb[1]) reload_capture_reg[15:8] <= wr_data[15:8];
      end
   end

   // software write to the count loses to a hardware reload
   // it also loses to a counting tick: stop the timer before loading it,
   // since a running count cannot be written reliably
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         count_reg <= `COUNT_RESET;
      end else if (down_wrap) begin
         count_reg <= `COUNT_TOP;
      end else if (do_reload) begin
         count_reg <= reload_capture_reg;
      end else if (tick) begin
         count_reg <= count_down ? count_reg - 16'd1 : count_reg + 16'd1;
      end else if (wr_cnt) begin
         if (wr_strb[0]) count_reg[7:0] <= wr_data[7:0];
         if (wr_strb[1]) count_reg[15:8] <= wr_data[15:8];
      end
   end

   // serial clock routing and interrupt request
   // ticks go out only on an up overflow; down underflows never clock the port
   // the request is registered, so it trails the flags by one cycle
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         RX_BAUD_TICK_OUT <= 1'b0;
         TX_BAUD_TICK_OUT <= 1'b0;
         IRQ_OUT <= 1'b0;
         MODE_OUT <= 2'b00;
      end else begin
         RX_BAUD_TICK_OUT <= up_wrap & rx_clock_select;
         TX_BAUD_TICK_OUT <= up_wrap & tx_clock_select;
         IRQ_OUT <= IRQ_ENABLE_IN
            & (overflow_flag | (external_event_flag & ~down_count_enable_reg));
         // mode leaves with the same edge as the ticks it describes
         MODE_OUT <= mode_next;
      end
   end

   // status mode: off wins, then baud, then the capture select
   always_comb begin
      if (!run_control) mode_next = MODE_OFF;
      else if (baud_mode) mode_next = MODE_BAUD;
      else if (capture_reload_select) mode_next = MODE_CAPTURE;
      else mode_next = MODE_RELOAD;
   end

   // axi4-lite write: address and data taken in either order
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         wr_reg <= '0;
         AWREADY_OUT <= 1'b0;
         WREADY_OUT <= 1'b0;
         BVALID_OUT <= 1'b0;
         BRESP_OUT <= `RESP_OKAY;
      end else begin
         // each ready is a one-cycle pulse, so a held valid is taken only once
         AWREADY_OUT <= ~aw_held_reg & ~AWREADY_OUT & AWVALID_IN & ~BVALID_OUT;
         WREADY_OUT <= ~w_held_reg & ~WREADY_OUT & WVALID_IN & ~BVALID_OUT;
         if (AWVALID_IN && AWREADY_OUT) begin
            aw_held_reg <= 1'b1;
            wr_reg.addr <= AWADDR_IN;
         end
         if (WVALID_IN && WREADY_OUT) begin
            w_held_reg <= 1'b1;
            wr_reg.data <= WDATA_IN;
            wr_reg.strb <= WSTRB_IN;
         end
         if (aw_held_reg && w_held_reg && !BVALID_OUT) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            BVALID_OUT <= 1'b1;
            BRESP_OUT <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (BVALID_OUT && BREADY_IN) begin
            BVALID_OUT <= 1'b0;
         end
      end
   end

   // reads decode the address as presented; unmapped ones read zero with an error
   rd_rsp_t rd_next;
   always_comb begin
      rd_next.resp = `RESP_OKAY;
      unique case (ARADDR_IN)
         `CTRL_OFFSET: rd_next.data = {24'h0, counter_control_reg};
         `MODE_OFFSET: rd_next.data = {31'h0, down_count_enable_reg};
         `RCAP_OFFSET: rd_next.data = {16'h0, reload_capture_reg};
         `COUNT_OFFSET: rd_next.data = {16'h0, count_reg};
         `STATUS_OFFSET: rd_next.data = {30'h0, mode_next};
         default: begin
            rd_next.data = 32'h0;
            rd_next.resp = `RESP_SLVERR;
         end
      endcase
   end

   // read data is taken at the address handshake and stands until rready
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         ARREADY_OUT <= 1'b0;
         RVALID_OUT <= 1'b0;
         RDATA_OUT <= 32'h0;
         RRESP_OUT <= `RESP_OKAY;
      end else begin
         ARREADY_OUT <= ARVALID_IN & ~ARREADY_OUT & ~RVALID_OUT;
         if (ARVALID_IN && ARREADY_OUT) begin
            RVALID_OUT <= 1'b1;
            RDATA_OUT <= rd_next.data;
            RRESP_OUT <= rd_next.resp;
         end else if (RVALID_OUT && RREADY_IN) begin
            RVALID_OUT <= 1'b0;
         end
      end
   end
endmodule : timer2_capture_reload_baud

// >>> rtl/timer2_cfg.svh
// timer2_cfg.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and the top module
`ifndef TIMER2_CFG_SVH
`define TIMER2_CFG_SVH
`define CTRL_OFFSET 8'h00
`define MODE_OFFSET 8'h04
`define RCAP_OFFSET 8'h08
`define COUNT_OFFSET 8'h0c
`define STATUS_OFFSET 8'h10
`define BIT_OVF 7
`define BIT_EXF 6
`define BIT_RCLK 5
`define BIT_TX_CLOCK_SELECT 4
`define BIT_EXEN 3
`define BIT_RUN 2
`define BIT_CSEL 1
`define BIT_CPRL 0
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define RCAP_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define COUNT_TOP 16'hffff
`define MACHINE_DIV 4'd12
`define STATE_DIV 4'd2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> rtl/timer2_pkg.sv
// timer2_pkg: types shared by the timer block
// assumes the cfg header supplies the numbers
`include "timer2_cfg.svh"
package timer2_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } wr_req_t;
   typedef struct packed {
      logic [31:0] data;
      logic [1:0] resp;
   } rd_rsp_t;
   typedef enum logic [1:0] {MODE_OFF, MODE_CAPTURE, MODE_RELOAD, MODE_BAUD} op_mode_t;
endpackage : timer2_pkg

// >>> testbench/timer2_capture_reload_baud_properties.sv
// timer2_capture_reload_baud_properties: port checks for the timer block
// assumes it is bound to the top module; one clock domain
`timescale 1ns/1ns
module timer2_checker (
   // watched ports
   input wire logic REF_CLK_IN, SRST_IN, IRQ_ENABLE_IN, IRQ_OUT, AWREADY_OUT,
   input wire logic BVALID_OUT, BREADY_IN, ARVALID_IN, ARREADY_OUT, RVALID_OUT,
   input wire logic RREADY_IN, RX_BAUD_TICK_OUT, TX_BAUD_TICK_OUT,
   input wire logic [1:0] MODE_OUT,
   input wire logic [31:0] RDATA_OUT
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (SRST_IN);
   chk_irq_masked: assert property (!IRQ_ENABLE_IN |=> !IRQ_OUT)
      else $error("irq without enable");
   // mode register shows baud in the cycle of each tick; the past value is also accepted
   chk_tick_baud: assert property (RX_BAUD_TICK_OUT || TX_BAUD_TICK_OUT |->
      MODE_OUT == 2'h3 || $past(MODE_OUT) == 2'h3) else $error("tick outside baud");
   chk_tick_pulse: assert property (RX_BAUD_TICK_OUT |=> !RX_BAUD_TICK_OUT)
      else $error("tick longer than a cycle");
   chk_tick_off: assert property (MODE_OUT == 2'h0 && $past(MODE_OUT, 2) == 2'h0 |->
      !RX_BAUD_TICK_OUT && !TX_BAUD_TICK_OUT) else $error("tick while off");
   chk_aw_pulse: assert property (AWREADY_OUT |=> !AWREADY_OUT)
      else $error("awready held");
   chk_b_release: assert property (BVALID_OUT && BREADY_IN |=> !BVALID_OUT)
      else $error("bvalid kept");
   chk_r_hold: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
      else $error("read answer moved");
   chk_r_answer: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
      else $error("read answer late");
endmodule : timer2_checker
bind timer2_capture_reload_baud timer2_checker i_chk (.REF_CLK_IN(REF_CLK_IN),
   .SRST_IN(SRST_IN), .IRQ_ENABLE_IN(IRQ_ENABLE_IN), .IRQ_OUT(IRQ_OUT),
   .AWREADY_OUT(AWREADY_OUT), .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN),
   .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT), .RVALID_OUT(RVALID_OUT),
   .RREADY_IN(RREADY_IN), .RX_BAUD_TICK_OUT(RX_BAUD_TICK_OUT),
   .TX_BAUD_TICK_OUT(TX_BAUD_TICK_OUT), .MODE_OUT(MODE_OUT), .RDATA_OUT(RDATA_OUT));

// >>> testbench/timer2_pins_model.sv
// timer2_pins_model: drives count and trigger pins, counts serial ticks
// assumes the bench calls its task; pins idle high as with pull-ups
`timescale 1ns/1ns
module timer2_pins_model (
   // clock and serial side
   input wire logic clk_in,
   input wire logic rx_tick_in,
   input wire logic tx_tick_in,
   // pins
   output logic count_pin_out = 1'h1,
   output logic trigger_pin_out = 1'h1
);
   int rx_n = 0;
   int tx_n = 0;
   int cyc_n = 0;
   int rx_last = 0;
   int rx_gap = 0;
   always @(posedge clk_in) begin
      cyc_n++;
      if (rx_tick_in) begin
         if (rx_n > 0) rx_gap = cyc_n - rx_last;
         rx_last = cyc_n;
         rx_n++;
      end
      if (tx_tick_in) tx_n++;
   end
   // holds the trigger at a level, which sets the direction in a down count
   task automatic level(input bit lvl);
      @(posedge clk_in);
      trigger_pin_out <= lvl;
   endtask : level
   // levels held two cycles so the sampler sees every fall once
   task automatic fall(input bit trig, input int n);
      repeat (n) begin
         @(posedge clk_in);
         if (trig) trigger_pin_out <= 1'h0;
         else count_pin_out <= 1'h0;
         repeat (2) @(posedge clk_in);
         if (trig) trigger_pin_out <= 1'h1;
         else count_pin_out <= 1'h1;
         repeat (2) @(posedge clk_in);
      end
   endtask : fall
endmodule : timer2_pins_model

// >>> testbench/timer2_capture_reload_baud_bench.sv
// timer2_capture_reload_baud_bench: register-level tests of the timer block
// assumes the bound checker and the pin model for the far side
`timescale 1ns/1ns
module timer2_capture_reload_baud_bench;
   import timer2_pkg::*;
   logic clk = 1'h0, srst = 1'h1, awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0;
   logic rrdy = 1'h0, irq_en = 1'h0, awr, wr_r, bv, arr, rv, irq, rxt, txt, cp, tp;
   logic [7:0] awa = 8'h0, ara = 8'h0;
   logic [31:0] wd = 32'h0, rdat, rd_val;
   logic [1:0] rresp, rd_resp, bresp, wr_resp;
   logic [3:0] ws = 4'hf;
   int bad_count = 0, n_checks = 0, cyc = 0, rx0, tx0;
   initial forever #50 clk = ~clk;
   timer2_capture_reload_baud i_dut (.REF_CLK_IN(clk), .SRST_IN(srst), .AWADDR_IN(awa),
      .AWVALID_IN(awv), .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(ws), .WVALID_IN(wv),
      .WREADY_OUT(wr_r), .BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(brdy), .ARADDR_IN(ara),
      .ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rdat), .RRESP_OUT(rresp),
      .RVALID_OUT(rv), .RREADY_IN(rrdy), .COUNT_PIN_IN(cp), .TRIGGER_PIN_IN(tp),
      .IRQ_ENABLE_IN(irq_en), .IRQ_OUT(irq), .RX_BAUD_TICK_OUT(rxt),
      .TX_BAUD_TICK_OUT(txt), .MODE_OUT());
   timer2_pins_model i_pins (.clk_in(clk), .rx_tick_in(rxt), .tx_tick_in(txt),
      .count_pin_out(cp), .trigger_pin_out(tp));
   task automatic ck(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask : ck
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      brdy <= 1'h1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'h0;
         if (wr_r) wv <= 1'h0;
      end while (bv !== 1'h1);
      wr_resp = bresp;
      brdy <= 1'h0;
   endtask : wr
   // rready waits for the answer so the standing read data is exercised
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
      end while (rv !== 1'h1);
      rrdy <= 1'h1;
      @(posedge clk);
      rd_val = rdat;
      rd_resp = rresp;
      rrdy <= 1'h0;
      ck($sformatf("reg %h", a), exp, rd_val);
   endtask : rc
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      rc(8'h00, 32'h0);
      rc(8'h0c, 32'h0);
      rc(8'h20, 32'h0);
      ck("unmapped resp", 32'h2, {30'h0, rd_resp});
      wr(8'h10, 32'h0);
      ck("ro write resp", 32'h2, {30'h0, wr_resp});
      $display("done reset");
      wr(8'h0c, 32'h10);
      ck("write resp", 32'h0, {30'h0, wr_resp});
      wr(8'h00, 32'h02);
      i_pins.fall(1'h0, 3);
      rc(8'h0c, 32'h10);
      wr(8'h00, 32'h06);
      i_pins.fall(1'h0, 3);
      rc(8'h0c, 32'h13);
      wr(8'h08, 32'h1234);
      wr(8'h0c, 32'hfffe);
      i_pins.fall(1'h0, 3);
      rc(8'h0c, 32'h1235);
      rc(8'h00, 32'h86);
      irq_en <= 1'h1;
      repeat (3) @(posedge clk);
      ck("irq", 32'h1, {31'h0, irq});
      wr(8'h00, 32'h06);
      repeat (3) @(posedge clk);
      ck("irq cleared", 32'h0, {31'h0, irq});
      $display("done overflow");
      wr(8'h0c, 32'h50);
      wr(8'h00, 32'h0f);
      i_pins.fall(1'h1, 1);
      rc(8'h08, 32'h50);
      rc(8'h0c, 32'h50);
      rc(8'h00, 32'h4f);
      ck("irq ext", 32'h1, {31'h0, irq});
      wr(8'h00, 32'h07);
      wr(8'h08, 32'haaa);
      i_pins.fall(1'h1, 1);
      rc(8'h08, 32'haaa);
      wr(8'h00, 32'h0e);
      i_pins.fall(1'h1, 1);
      rc(8'h0c, 32'haaa);
      rc(8'h00, 32'h4e);
      wr(8'h04, 32'h1);
      repeat (3) @(posedge clk);
      ck("irq down", 32'h0, {31'h0, irq});
      wr(8'h00, 32'h0e);
      i_pins.level(1'h0);
      i_pins.fall(1'h0, 2);
      rc(8'h0c, 32'hfffe);
      rc(8'h00, 32'hce);
      i_pins.level(1'h1);
      $display("done trigger");
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0);
      ws <= 4'h2;
      wr(8'h08, 32'h1200);
      rc(8'h08, 32'h12aa);
      ws <= 4'hf;
      wr(8'h08, 32'hfff0);
      wr(8'h0c, 32'hfff0);
      rx0 = i_pins.rx_n;
      tx0 = i_pins.tx_n;
      wr(8'h00, 32'h34);
      repeat (200) @(posedge clk);
      rc(8'h00, 32'h34);
      rc(8'h10, 32'h3);
      wr(8'h00, 32'h0);
      ck("rx ticks", 32'h1, {31'h0, i_pins.rx_n > rx0});
      ck("tx ticks", 32'(i_pins.rx_n - rx0), 32'(i_pins.tx_n - tx0));
      ck("rx period", 32'h20, 32'(i_pins.rx_gap));
      $display("done baud");
      summarize();
   end
endmodule : timer2_capture_reload_baud_bench
